// ===== rtl/tsr_regs.svh
// Purpose: Offsets, field positions, reset values and scale constants.
// Assumes: Included once per compile unit through its guard.
// Notes:   Time stamps are kept in 0.1 ns units.
//
// Summary of operation
// - Lower time count adds time overflow correction.
// - Block first samples also get rollover checks.
// - Stamp is count times 2 ns minus interpolator.
// - Rollover correction precedes interpolator merge.
// - Interval output is later stamp minus earlier.
// - Armed block first sample is arming time.
// - Path offset subtracted from armed block first only.
// - Status bit 6 set marks block first.
// - Arming-to-first-edge interval is not reported.
// - Report first stamp minus arming stamp once.
// - Frequency is events over time, period inverse.
// - Missed events are event difference minus one.
// - Gate time is elapsed time between samples.
// - Event counts are rollover corrected first.
// - Third channel event stamps are multiplied four.
// - Records carry time, interpolator, flags, events.
// - Times-four scaling follows event rollover fix.
// - Lower event count adds event overflow correction.
`ifndef TSR_REGS_SVH
`define TSR_REGS_SVH

`define CTRL_ADDR   4'h0
`define TOVF_ADDR   4'h4
`define EOVF_ADDR   4'h8
`define OFFS_ADDR   4'hC
`define STAT_ADDR   4'h3
`define RCNT_ADDR   4'h7

`define CTRL_W      6
`define CTRL_FREQ   0
`define CTRL_PER    1
`define CTRL_EXP    2
`define CTRL_CHC    3
`define CTRL_ARMED  4
`define CTRL_CLR    5

`define CTRL_RST    6'h00
`define TOVF_RST    32'h0100_0000
`define EOVF_RST    32'h0100_0000
`define OFFS_RST    32'h0000_0000

`define FIRST_BIT   6
`define INH_BIT     7
`define INTERP_W    6

`define COARSE_PS   2000
`define FINE_PS     100
`define TICK_RATIO  48'(`COARSE_PS / `FINE_PS)
`define FRAC_BITS   32

`endif

// ===== rtl/tsr_pkg.sv
// Purpose: Types shared by the reconstruction block and its bench.
// Assumes: Widths fixed at the sample record layout.
// Notes:   Result values are 0.1 ns units, plain counts or rates with 32 fraction bits.
package tsr_pkg;

   // One raw sample record from the measurement hardware.
   typedef struct packed {
      logic [23:0] time_cnt;
      logic [23:0] ev_cnt;
      logic [7:0]  int_stat;
   } sample_s;

   typedef enum logic [2:0] {
      RK_CTI    = 3'h0,
      RK_ARM    = 3'h1,
      RK_MISSED = 3'h2,
      RK_GATE   = 3'h3,
      RK_FREQ   = 3'h4,
      RK_PERIOD = 3'h5
   } result_kind_e;

   typedef struct packed {
      result_kind_e kind;
      logic         inhibit;
      logic [63:0]  value;
   } result_s;

   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_PRI  = 3'b001,
      S_SEC  = 3'b011,
      S_DIV  = 3'b010,
      S_QUO  = 3'b110
   } step_e;

endpackage

// ===== rtl/quot_div.sv
// Purpose: Serial restoring divider, one quotient bit per clock.
// Assumes: start is ignored while a division is running.
// Notes:   Division by zero yields an all-ones quotient.
`timescale 1ns/1ps
module quot_div (
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        start,
   input  wire logic [63:0] num,
   input  wire logic [63:0] den,
   output logic             busy,
   output logic             done,
   output logic [63:0]      quot
);
   logic [64:0] rem_ff;
   logic [63:0] q_ff;
   logic [63:0] d_ff;
   logic [6:0]  cnt_ff;
   logic [64:0] trial;

   // Trial subtraction of the divisor from the shifted remainder.
   assign trial = {rem_ff[63:0], q_ff[63]} - {1'b0, d_ff};
   assign busy  = cnt_ff != 7'h00;
   assign quot  = q_ff;

   // Shift loop; done pulses the cycle after the last bit lands.
   always_ff @(posedge clk) begin
      if (reset) begin
         rem_ff <= 65'h0;
         q_ff   <= 64'h0;
         d_ff   <= 64'h0;
         cnt_ff <= 7'h00;
         done   <= 1'b0;
      end else begin
         done <= cnt_ff == 7'h01;
         if (start && !busy) begin
            rem_ff <= 65'h0;
            q_ff   <= num;
            d_ff   <= den;
            cnt_ff <= 7'h40;
         end else if (busy) begin
            cnt_ff <= cnt_ff - 7'h01;
            if (!trial[64]) begin
               rem_ff <= trial;
               q_ff   <= {q_ff[62:0], 1'b1};
            end else begin
               rem_ff <= {rem_ff[63:0], q_ff[63]};
               q_ff   <= {q_ff[62:0], 1'b0};
            end
         end
      end
   end
endmodule

// ===== rtl/time_stamp_reconstruction.sv
// Purpose: Turns raw sample records into time stamps and results.
// Assumes: Registers are written before the first sample arrives.
// Notes:   One sample is taken per idle cycle; results are pulses.
//
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`include "tsr_regs.svh"
module time_stamp_reconstruction (
   input  wire logic             clk,
   input  wire logic             reset,
   input  wire logic [3:0]       reg_addr,
   input  wire logic [31:0]      reg_wdata,
   input  wire logic             reg_wr,
   input  wire logic             reg_rd,
   output logic [31:0]           reg_rdata,
   input  wire logic             smp_valid,
   input  wire tsr_pkg::sample_s smp,
   output logic                  smp_ready,
   output logic                  res_valid,
   output tsr_pkg::result_s      res
);
   import tsr_pkg::*;

   logic [`CTRL_W-1:0] ctrl_ff;
   logic [31:0]        tovf_ff;
   logic [31:0]        eovf_ff;
   logic [31:0]        offs_ff;
   logic [31:0]        rcnt_ff;
   step_e              step_ff;
   step_e              nxt_step;
   logic [23:0]        tprev_ff;
   logic [39:0]        tadd_ff;
   logic               tseen_ff;
   logic [23:0]        eprev_ff;
   logic [39:0]        eadd_ff;
   logic               eseen_ff;
   logic [47:0]        ts_prev_ff;
   logic               tsv_ff;
   logic [41:0]        es_prev_ff;
   logic               esv_ff;
   logic [47:0]        arm_ff;
   logic               arm_pend_ff;
   logic [47:0]        dt_ff;
   logic [41:0]        de_ff;
   logic [63:0]        pri_ff;
   result_kind_e       pri_kind_ff;
   logic               inh_ff;
   logic               accept;
   logic               clr;
   logic               first;
   logic               armed_first;
   logic               has_ev;
   logic               t_roll;
   logic               e_roll;
   logic [39:0]        tadd_n;
   logic [39:0]        tcorr;
   logic [39:0]        eadd_n;
   logic [39:0]        ecorr;
   logic [47:0]        tstamp;
   logic [41:0]        estamp;
   logic [47:0]        dt_n;
   logic [41:0]        de_n;
   logic               div_start;
   logic               div_done;
   logic [63:0]        div_quot;
   logic [63:0]        div_num;
   logic [63:0]        div_den;

   // Stream waits while results pend, and in a clear cycle too, so a
   // sample taken then can never be lost to the clearing of state.
   assign smp_ready = step_ff == S_IDLE && !clr;
   assign accept    = smp_valid && smp_ready;
   assign clr       = reg_wr && reg_addr == `CTRL_ADDR
                      && reg_wdata[`CTRL_CLR];
   assign first     = smp.int_stat[`FIRST_BIT];
   assign armed_first = first && ctrl_ff[`CTRL_ARMED];
   // The arming sample of a block-armed record carries no event.
   assign has_ev = (ctrl_ff[`CTRL_FREQ] || ctrl_ff[`CTRL_EXP])
                   && !armed_first;

   // Time rollover is checked against every predecessor, block
   // starts included, and is folded in before the stamp is built.
   assign t_roll = tseen_ff && smp.time_cnt < tprev_ff;
   assign tadd_n = t_roll ? tadd_ff + {8'h00, tovf_ff} : tadd_ff;
   assign tcorr  = {16'h0000, smp.time_cnt} + tadd_n;

   // Stamp in 0.1 ns units; offset only on the arming sample.
   assign tstamp = 48'(tcorr) * `TICK_RATIO
                   - 48'(smp.int_stat[`INTERP_W-1:0])
                   - (armed_first ? {16'h0000, offs_ff}
                                  : 48'h0);

   // Event rollover first, then the third-channel scaling.
   assign e_roll = eseen_ff && smp.ev_cnt < eprev_ff;
   assign eadd_n = e_roll ? eadd_ff + {8'h00, eovf_ff} : eadd_ff;
   assign ecorr  = {16'h0000, smp.ev_cnt} + eadd_n;
   assign estamp = ctrl_ff[`CTRL_CHC] ? {ecorr, 2'b00}
                                      : {2'b00, ecorr};

   assign dt_n = tstamp - ts_prev_ff;
   assign de_n = estamp - es_prev_ff;

   // Configuration registers; the clear bit is a pulse, not stored.
   always_ff @(posedge clk) begin
      if (reset) begin
         ctrl_ff <= `CTRL_RST;
         tovf_ff <= `TOVF_RST;
         eovf_ff <= `EOVF_RST;
         offs_ff <= `OFFS_RST;
      end else if (reg_wr) begin
         case (reg_addr)
            `CTRL_ADDR: ctrl_ff <= {1'b0, reg_wdata[`CTRL_W-2:0]};
            `TOVF_ADDR: tovf_ff <= reg_wdata;
            `EOVF_ADDR: eovf_ff <= reg_wdata;
            `OFFS_ADDR: offs_ff <= reg_wdata;
            default:    ctrl_ff <= ctrl_ff;
         endcase
      end
   end

   // Read data stands only in the cycle after the read strobe.
   always_ff @(posedge clk) begin
      if (reset) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_rd) begin
         case (reg_addr)
            `CTRL_ADDR: reg_rdata <= {26'h0, ctrl_ff};
            `TOVF_ADDR: reg_rdata <= tovf_ff;
            `EOVF_ADDR: reg_rdata <= eovf_ff;
            `OFFS_ADDR: reg_rdata <= offs_ff;
            `STAT_ADDR: reg_rdata <= {24'h0, arm_pend_ff, tsv_ff,
                                      esv_ff, tseen_ff, 1'b0, step_ff};
            `RCNT_ADDR: reg_rdata <= rcnt_ff;
            default:    reg_rdata <= 32'h0000_0000;
         endcase
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end

   // Time rollover tracker spans the whole stream.
   always_ff @(posedge clk) begin
      if (reset || clr) begin
         tprev_ff <= 24'h0;
         tadd_ff  <= 40'h0;
         tseen_ff <= 1'b0;
      end else if (accept) begin
         tprev_ff <= smp.time_cnt;
         tadd_ff  <= tadd_n;
         tseen_ff <= 1'b1;
      end
   end

   // Event rollover tracker skips samples that carry no event.
   always_ff @(posedge clk) begin
      if (reset || clr) begin
         eprev_ff <= 24'h0;
         eadd_ff  <= 40'h0;
         eseen_ff <= 1'b0;
      end else if (accept && has_ev) begin
         eprev_ff <= smp.ev_cnt;
         eadd_ff  <= eadd_n;
         eseen_ff <= 1'b1;
      end
   end

   // Stamp history. A block start breaks the pairing so that no
   // interval or rate straddles two blocks.
   always_ff @(posedge clk) begin
      if (reset || clr) begin
         ts_prev_ff  <= 48'h0;
         tsv_ff      <= 1'b0;
         es_prev_ff  <= 42'h0;
         esv_ff      <= 1'b0;
         arm_ff      <= 48'h0;
         arm_pend_ff <= 1'b0;
         dt_ff       <= 48'h0;
         de_ff       <= 42'h0;
         inh_ff      <= 1'b0;
      end else if (accept) begin
         inh_ff <= smp.int_stat[`INH_BIT];
         dt_ff  <= dt_n;
         de_ff  <= de_n;
         if (armed_first) begin
            arm_ff      <= tstamp;
            arm_pend_ff <= 1'b1;
            tsv_ff      <= 1'b0;
            esv_ff      <= 1'b0;
         end else begin
            arm_pend_ff <= 1'b0;
            ts_prev_ff  <= tstamp;
            tsv_ff      <= 1'b1;
            es_prev_ff  <= estamp;
            esv_ff      <= has_ev;
         end
      end
   end

   // Chooses what the accepted sample yields. The pair of arming
   // stamp and first edge gives the arming value, never an interval.
   always_ff @(posedge clk) begin
      if (reset) begin
         pri_ff      <= 64'h0;
         pri_kind_ff <= RK_CTI;
      end else if (accept) begin
         if (arm_pend_ff) begin
            pri_ff      <= 64'(tstamp - arm_ff);
            pri_kind_ff <= RK_ARM;
         end else begin
            pri_ff      <= 64'(dt_n);
            pri_kind_ff <= ctrl_ff[`CTRL_FREQ] ? RK_GATE : RK_CTI;
         end
      end
   end

   // Sequencing of results for one sample.
   always_comb begin
      nxt_step = step_ff;
      case (step_ff)
         S_IDLE: begin
            if (accept && !armed_first) begin
               if (arm_pend_ff) begin
                  nxt_step = S_PRI;
               end else if (tsv_ff && !first) begin
                  if (!ctrl_ff[`CTRL_FREQ]) begin
                     nxt_step = S_PRI;
                  end else if (esv_ff && has_ev) begin
                     nxt_step = ctrl_ff[`CTRL_EXP] ? S_PRI : S_DIV;
                  end
               end
            end
         end
         S_PRI: begin
            if (pri_kind_ff == RK_ARM) begin
               nxt_step = S_IDLE;
            end else if (ctrl_ff[`CTRL_FREQ]) begin
               nxt_step = S_DIV;
            end else begin
               nxt_step = ctrl_ff[`CTRL_EXP] ? S_SEC : S_IDLE;
            end
         end
         S_SEC:   nxt_step = S_IDLE;
         S_DIV:   nxt_step = div_done ? S_QUO : S_DIV;
         S_QUO:   nxt_step = S_IDLE;
         default: nxt_step = S_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset || clr) begin
         step_ff <= S_IDLE;
      end else begin
         step_ff <= nxt_step;
      end
   end

   // Frequency keeps 32 fraction bits of events per 0.1 ns; period
   // is whole 0.1 ns per event. Wider operands would cost cycles.
   assign div_num = ctrl_ff[`CTRL_PER] ? {16'h0, dt_ff}
                    : {de_ff[31:0], {`FRAC_BITS{1'b0}}};
   assign div_den = ctrl_ff[`CTRL_PER] ? {22'h0, de_ff}
                    : {16'h0, dt_ff};
   assign div_start = step_ff == S_DIV && nxt_step == S_DIV
                      && !div_done;

   // A clear also stops a division in flight, so that a stale done can
   // never finish the next rate result with an old quotient.
   quot_div u_div (
      .clk   (clk),
      .reset (reset || clr),
      .start (div_start),
      .num   (div_num),
      .den   (div_den),
      .busy  (),
      .done  (div_done),
      .quot  (div_quot)
   );

   // Result register; one pulse per result.
   always_ff @(posedge clk) begin
      if (reset) begin
         res_valid <= 1'b0;
         res       <= '0;
         rcnt_ff   <= 32'h0;
      end else begin
         res_valid <= 1'b0;
         case (step_ff)
            S_PRI: begin
               res_valid <= 1'b1;
               res       <= '{pri_kind_ff, inh_ff, pri_ff};
            end
            S_SEC: begin
               res_valid <= 1'b1;
               res       <= '{RK_MISSED, inh_ff,
                              64'(de_ff) - 64'h1};
            end
            S_QUO: begin
               res_valid <= 1'b1;
               res       <= '{ctrl_ff[`CTRL_PER] ? RK_PERIOD : RK_FREQ,
                              inh_ff, div_quot};
            end
            default: res_valid <= 1'b0;
         endcase
         // A result issued in the clear cycle still counts; the set wins.
         if (step_ff == S_PRI || step_ff == S_SEC
             || step_ff == S_QUO) begin
            rcnt_ff <= (clr ? 32'h0 : rcnt_ff) + 32'h1;
         end else if (clr) begin
            rcnt_ff <= 32'h0;
         end
      end
   end

   // Checks on the datapath.
   AST_ROLL: assert property (@(posedge clk) disable iff (reset)
      accept && !clr && t_roll |=>
      tadd_ff == $past(tadd_ff) + {8'h00, $past(tovf_ff)})
      else $error("Time rollover correction not added.");

   AST_NOROLL: assert property (@(posedge clk) disable iff (reset)
      accept && !clr && tseen_ff && !t_roll |=> $stable(tadd_ff))
      else $error("Time correction changed without rollover.");

   AST_STAMP: assert property (@(posedge clk) disable iff (reset)
      accept && !clr && !armed_first |=> ts_prev_ff ==
      48'($past(tcorr)) * 48'd20 - 48'($past(smp.int_stat[5:0])))
      else $error("Time stamp formula mismatch.");

   AST_OFFS: assert property (@(posedge clk) disable iff (reset)
      accept && !clr && armed_first |=> arm_ff == 48'($past(tcorr))
      * 48'd20 - 48'($past(smp.int_stat[5:0]))
      - {16'h0, $past(offs_ff)})
      else $error("Arming stamp offset mismatch.");

   AST_FIRST: assert property (@(posedge clk) disable iff (reset)
      accept && armed_first |=> step_ff == S_IDLE ##1 !res_valid)
      else $error("Arming sample produced a result.");

   AST_ARM: assert property (@(posedge clk) disable iff (reset)
      step_ff == S_PRI && pri_kind_ff == RK_ARM |=>
      res_valid && res.kind == RK_ARM ##1 !res_valid)
      else $error("Arming value not reported once.");

   AST_MISS: assert property (@(posedge clk) disable iff (reset)
      step_ff == S_SEC |=> res_valid && res.kind == RK_MISSED
      && res.value == 64'($past(de_ff)) - 64'h1)
      else $error("Missed event count mismatch.");

   AST_CHC: assert property (@(posedge clk) disable iff (reset)
      accept && !clr && has_ev && !armed_first && ctrl_ff[3]
      |=> es_prev_ff[1:0] == 2'b00)
      else $error("Third channel event stamp not scaled.");

   AST_DIV: assert property (@(posedge clk) disable iff (reset)
      step_ff == S_IDLE ##1 step_ff == S_DIV |->
      ##[1:70] res_valid && (res.kind == RK_FREQ
      || res.kind == RK_PERIOD))
      else $error("Rate result not produced in time.");

endmodule

// ===== bench/sample_source.sv
// Purpose: Model of the measurement hardware offering sample records.
// Assumes: The bench queues records through put.
// Notes:   Between records the bus is inverted each idle cycle, so old data returns every second cycle.
`timescale 1ns/1ps
module sample_source (
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        slow,
   input  wire logic        smp_ready,
   output logic             smp_valid = 1'b0,
   output tsr_pkg::sample_s smp = '0
);
   import tsr_pkg::*;
   sample_s q[$];
   int      gap = 0;

   // Queues one record for delivery.
   task automatic put(input sample_s s);
      q.push_back(s);
   endtask

   // Offers each record until taken; a slow source idles between records.
   always @(posedge clk) begin
      if (reset) begin
         smp_valid <= 1'b0;
         gap       <= 0;
      end else if (!smp_valid || smp_ready) begin
         if (q.size() > 0 && gap == 0) begin
            smp       <= q.pop_front();
            smp_valid <= 1'b1;
            gap       <= slow ? 3 : 0;
         end else begin
            smp_valid <= 1'b0;
            smp       <= sample_s'(~smp);
            if (gap > 0)
               gap <= gap - 1;
         end
      end
   end
endmodule

// ===== bench/time_stamp_reconstruction_tb.sv
// Purpose: Self-checking bench for the time stamp reconstruction block.
// Assumes: Results come out in the order the samples went in.
// Notes:   The expected stream is computed as each sample is queued.
`timescale 1ns/1ps
`include "tsr_regs.svh"
module time_stamp_reconstruction_tb;
   import tsr_pkg::*;
   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic        slow = 1'b0;
   logic [3:0]  reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic [31:0] reg_rdata;
   logic        smp_valid, smp_ready, res_valid;
   sample_s     smp;
   result_s     res;
   result_s     exp_q[$];
   logic [31:0] rnd = 32'h0001_5589;
   logic [31:0] tovf, eovf, offs;
   logic [5:0]  ctrl = 6'h00;
   logic [23:0] tcnt = 24'hFFC000;
   logic [23:0] ecnt = 24'hFFFFF8;
   logic [23:0] prv_t, prv_e;
   logic [63:0] tacc = 64'h0;
   logic [63:0] eacc = 64'h0;
   logic [63:0] pst, pev, arm_st;
   logic        tseen = 1'b0;
   logic        eseen = 1'b0;
   logic        have = 1'b0;
   logic        armp = 1'b0;
   int          fail_count = 0;
   int          num_checks = 0;
   int          nres = 0;

   always #5 clk = ~clk;

   time_stamp_reconstruction u_time_stamp_reconstruction (
      .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .smp_valid(smp_valid), .smp(smp), .smp_ready(smp_ready),
      .res_valid(res_valid), .res(res));

   sample_source u_sample_source (
      .clk(clk), .reset(reset), .slow(slow), .smp_ready(smp_ready),
      .smp_valid(smp_valid), .smp(smp));

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic chk_reg(input string n, input logic [31:0] e, g);
      num_checks++;
      if (g !== e) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic chk_res(input string n, input result_s e, g);
      num_checks++;
      if (g !== e) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask

   // Bus cycles; each leaves one idle cycle so no strobe is set twice.
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rd(input string n, input logic [3:0] a, logic [31:0] e);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
      chk_reg(n, e, reg_rdata);
   endtask

   // Reference model of the reconstruction, fed one record at a time.
   task automatic model(input sample_s s);
      logic [63:0] st, ev, dt, de;
      logic        first, inh;
      ev = 64'h0;
      first = s.int_stat[`FIRST_BIT];
      inh = s.int_stat[`INH_BIT];
      if (tseen && s.time_cnt < prv_t)
         tacc = tacc + 64'(tovf);
      tseen = 1'b1;
      prv_t = s.time_cnt;
      st = (64'(s.time_cnt) + tacc) * 64'd20 - 64'(s.int_stat[5:0]);
      if ((ctrl[0] || ctrl[2]) && !(ctrl[4] && first)) begin
         if (eseen && s.ev_cnt < prv_e)
            eacc = eacc + 64'(eovf);
         eseen = 1'b1;
         prv_e = s.ev_cnt;
         ev = (64'(s.ev_cnt) + eacc) << (ctrl[3] ? 2 : 0);
      end
      dt = st - pst;
      de = ev - pev;
      if (first) begin
         armp = ctrl[4];
         have = !ctrl[4];
         arm_st = st - 64'(offs);
      end else if (armp) begin
         exp_q.push_back(result_s'{RK_ARM, inh, st - arm_st});
         armp = 1'b0;
         have = 1'b1;
      end else if (have && !ctrl[0]) begin
         exp_q.push_back(result_s'{RK_CTI, inh, dt});
         if (ctrl[2])
            exp_q.push_back(result_s'{RK_MISSED, inh, de - 64'h1});
      end else if (have) begin
         if (ctrl[2])
            exp_q.push_back(result_s'{RK_GATE, inh, dt});
         if (ctrl[1])
            exp_q.push_back(result_s'{RK_PERIOD, inh,
                            de == 64'h0 ? '1 : dt / de});
         else
            exp_q.push_back(result_s'{RK_FREQ, inh,
                            dt == 64'h0 ? '1 : {de[31:0], 32'h0} / dt});
      end else
         have = 1'b1;
      pst = st;
      pev = ev;
   endtask

   // Waits, bounded, until every queued record has produced its results.
   task automatic drain();
      int k;
      k = 0;
      while ((exp_q.size() > 0 || u_sample_source.q.size() > 0)
             && k < 5000) begin
         @(posedge clk);
         k++;
      end
      if (k >= 5000) begin
         fail_count++;
         $display("BAD drain expected 0 seen %0d", exp_q.size());
         end_sim();
      end
      repeat (80) @(posedge clk);
   endtask

   task automatic run(input string n, input logic [5:0] c, input int cnt,
                      input int blk);
      sample_s s;
      ctrl = c;
      slow <= rnd[9];
      wr(`CTRL_ADDR, 32'(c));
      for (int i = 0; i < cnt; i++) begin
         rnd = lfsr(rnd);
         // Four counts at least, so stamps keep rising past any interpolator.
         tcnt = tcnt + 24'(rnd[11:0]) + 24'h4;
         ecnt = ecnt + 24'(rnd[15:12]) + 24'h1;
         s = '{tcnt, ecnt, {rnd[16], (i % blk == 0), rnd[22:17]}};
         model(s);
         u_sample_source.put(s);
      end
      drain();
      $display("test %s done", n);
   endtask

   // Every result is compared against the head of the expected queue.
   always @(posedge clk) begin
      if (!reset && res_valid) begin
         nres++;
         if (exp_q.size() == 0) begin
            fail_count++;
            $display("BAD result expected none seen %h", res);
         end else
            chk_res("result", exp_q.pop_front(), res);
      end
   end

   // Main sequence: registers first, then each measurement mode.
   initial begin
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      rd("ctrl", `CTRL_ADDR, 32'h0);
      rd("tovf", `TOVF_ADDR, `TOVF_RST);
      rd("eovf", `EOVF_ADDR, `EOVF_RST);
      rd("offs", `OFFS_ADDR, `OFFS_RST);
      rd("stat", `STAT_ADDR, 32'h0);
      rnd = lfsr(rnd);
      tovf = 32'h0100_0000 + 32'(rnd[23:0]);
      eovf = 32'h0100_0000 + 32'(rnd[31:24]);
      offs = 32'(rnd[13:0]);
      wr(`TOVF_ADDR, tovf);
      rd("tovf", `TOVF_ADDR, tovf);
      wr(`EOVF_ADDR, eovf);
      rd("eovf", `EOVF_ADDR, eovf);
      wr(`OFFS_ADDR, offs);
      rd("offs", `OFFS_ADDR, offs);
      wr(`CTRL_ADDR, 32'h0000_003F);
      rd("ctrl", `CTRL_ADDR, 32'h0000_001F);
      wr(4'h1, 32'hFFFF_FFFF);
      rd("unmapped", 4'h1, 32'h0);
      $display("test registers done");
      run("cti_expanded", 6'h04, 24, 8);
      run("cti_plain", 6'h00, 12, 6);
      tcnt = 24'hFFFF00;
      run("armed", 6'h10, 16, 4);
      run("freq", 6'h05, 10, 5);
      run("period_c", 6'h0F, 10, 5);
      run("freq_c", 6'h09, 8, 4);
      rd("rcnt", `RCNT_ADDR, 32'(nres));
      rd("stat_end", `STAT_ADDR, 32'h0000_0070);
      end_sim();
   end
endmodule
